// *** hdl/transmit_command_view_pkg.sv ***
// Constants, register map and carrier structs for the transmit command block.
// Assumes a 32-bit Avalon-MM slave with byte addresses and one clock, mclk.
`default_nettype none

// ==========================================================================
// Package
package tx_command_pkg;

  // Register indices as printed; byte address is four times the index.
  localparam logic [11:0] IDX_TX_CMD_VIEW  = 12'h108;
  localparam logic [11:0] IDX_BUF_CFG      = 12'h10a;
  localparam logic [11:0] IDX_BUF_EVENT    = 12'h12c;
  localparam logic [11:0] IDX_TX_CMD_WRITE = 12'h144;
  localparam logic [11:0] IDX_TX_LENGTH    = 12'h146;

  localparam logic [11:0] ADDR_TX_CMD_VIEW  = 12'h420;
  localparam logic [11:0] ADDR_BUF_CFG      = 12'h428;
  localparam logic [11:0] ADDR_BUF_EVENT    = 12'h4b0;
  localparam logic [11:0] ADDR_TX_CMD_WRITE = 12'h510;
  localparam logic [11:0] ADDR_TX_LENGTH    = 12'h518;

  // Identifier patterns in the low six bits.
  localparam logic [5:0] ID_TX_CMD   = 6'h09;
  localparam logic [5:0] ID_BUF_CFG  = 6'h0b;
  localparam logic [5:0] ID_BUF_EVT  = 6'h0c;

  localparam logic [15:0] RESET_TX_CMD  = 16'h0009;
  localparam logic [15:0] RESET_BUF_CFG = 16'h000b;

  // Transmit command fields.
  localparam int POS_START_LO    = 6;
  localparam int POS_PURGE       = 8;
  localparam int POS_ONE_COLL    = 9;
  localparam int POS_CRC_SUPP    = 12;
  localparam int POS_PAD_DIS     = 13;

  // Buffer configuration enables and buffer event bits share positions.
  localparam int POS_SW_INT      = 6;
  localparam int POS_RX_DMA      = 7;
  localparam int POS_TX_SPACE    = 8;
  localparam int POS_TX_UNDERRUN = 9;
  localparam int POS_RX_LOST     = 10;
  localparam int POS_EARLY_RX    = 11;
  localparam int POS_COLL_WRAP   = 12;
  localparam int POS_MISS_WRAP   = 13;
  localparam int POS_DEST_MATCH  = 15;

  localparam logic [15:0] CFG_WRITABLE = 16'hbfc0;
  localparam logic [15:0] EVT_MASK     = 16'hbfc0;

  // Start thresholds in bytes.
  localparam logic [10:0] THRESH_CODE0 = 11'd5;
  localparam logic [10:0] THRESH_CODE1 = 11'd381;
  localparam logic [10:0] THRESH_CODE2 = 11'd1021;
  localparam logic [10:0] MIN_TX_LENGTH = 11'd3;
  localparam logic [10:0] PAD_LENGTH    = 11'd60;
  localparam logic [4:0]  MAX_COLLISIONS = 5'd16;
  localparam logic [7:0]  EARLY_RX_BYTES = 8'd128;
  localparam logic [9:0]  WRAP_FROM      = 10'h1ff;

  typedef struct packed {
    logic       padding_disable;
    logic       crc_suppress;
    logic       one_collision;
    logic       purge;
    logic [1:0] start_threshold;
  } tx_cmd_s;

  typedef struct packed {
    logic start;
    logic purge;
    logic abort_bad_crc;
    logic retry;
    logic give_up;
    logic refuse;
    logic append_crc;
    logic pad_to_min;
  } tx_ctrl_s;

  typedef struct packed {
    logic rx_dma_done;
    logic tx_space_ready;
    logic tx_underrun;
    logic rx_lost;
    logic rx_frame_start;
    logic rx_byte;
    logic rx_dest_match;
  } buf_events_s;

  function automatic logic [10:0] threshold_bytes(input logic [1:0] code,
                                                  input logic [10:0] len);
    case (code)
      2'b00:   threshold_bytes = THRESH_CODE0;
      2'b01:   threshold_bytes = THRESH_CODE1;
      2'b10:   threshold_bytes = THRESH_CODE2;
      default: threshold_bytes = len;
    endcase
  endfunction : threshold_bytes

  function automatic logic [15:0] merge_be(input logic [15:0] old_v,
                                           input logic [15:0] new_v,
                                           input logic [1:0]  be);
    merge_be = {be[1] ? new_v[15:8] : old_v[15:8], be[0] ? new_v[7:0] : old_v[7:0]};
  endfunction : merge_be

endpackage : tx_command_pkg

`default_nettype wire

// *** hdl/tx_policy.sv ***
// Transmit policy engine: start threshold, purge, collision limit, pad and CRC.
// Assumes MAC strobes on mclk, one cycle wide, and a stable length per command.
`default_nettype none

// ==========================================================================
// Transmit policy
module tx_policy
  import tx_command_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic        cmd_strobe,
  input  wire tx_cmd_s     cmd,
  input  wire logic [10:0] tx_length,
  input  wire logic [10:0] tx_bytes_buffered,
  input  wire logic        tx_collision,
  input  wire logic        tx_done,
  output var  tx_ctrl_s    ctrl
);

  typedef enum logic [1:0] {IDLE, WAIT_DATA, SENDING} tx_state_e;

  tx_state_e   state;
  tx_cmd_s     active;
  logic [10:0] length;
  logic [4:0]  collisions;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state      <= IDLE;
      active     <= '0;
      length     <= '0;
      collisions <= '0;
      ctrl       <= '0;
    end else begin
      ctrl.start         <= 1'b0;
      ctrl.purge         <= 1'b0;
      ctrl.abort_bad_crc <= 1'b0;
      ctrl.retry         <= 1'b0;
      ctrl.give_up       <= 1'b0;
      ctrl.refuse        <= 1'b0;
      if (cmd_strobe) begin
        active     <= cmd;
        length     <= tx_length;
        collisions <= '0;
        if (cmd.purge) begin
          ctrl.purge <= 1'b1;
          // Abort is raised at once, well inside the 64 bit-time bound.
          ctrl.abort_bad_crc <= (state == SENDING);
        end
        if (tx_length < MIN_TX_LENGTH) begin
          ctrl.refuse <= 1'b1;
          state       <= IDLE;
        end else begin
          state <= WAIT_DATA;
        end
      end else begin
        case (state)
          IDLE: begin
            state <= IDLE;
          end
          WAIT_DATA: begin
            if (tx_bytes_buffered >= threshold_bytes(active.start_threshold, length)) begin
              ctrl.start      <= 1'b1;
              ctrl.append_crc <= ~active.crc_suppress;
              ctrl.pad_to_min <= ~active.padding_disable && (length < PAD_LENGTH);
              state           <= SENDING;
            end
          end
          SENDING: begin
            if (tx_done) begin
              state <= IDLE;
            end else if (tx_collision) begin
              collisions <= collisions + 5'd1;
              if (active.one_collision) begin
                ctrl.give_up <= 1'b1;
                state        <= IDLE;
              end else if (collisions + 5'd1 >= MAX_COLLISIONS) begin
                ctrl.give_up <= 1'b1;
                state        <= IDLE;
              end else begin
                ctrl.retry <= 1'b1;
              end
            end
          end
          default: begin
            state <= IDLE;
          end
        endcase
      end
    end
  end

endmodule : tx_policy

`default_nettype wire

// *** hdl/buf_events.sv ***
// Sticky buffer events, early receive counter, counter wraps and interrupt gate.
// Assumes event strobes on mclk, one cycle wide.
`default_nettype none

// ==========================================================================
// Buffer events
module buf_events
  import tx_command_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire buf_events_s ev,
  input  wire logic        tx_collision,
  input  wire logic        sw_request,
  input  wire logic        clear,
  input  wire logic [15:0] enables,
  output logic [15:0]      status,
  output logic             irq
);

  logic [7:0]  rx_count;
  logic [9:0]  coll_count;
  logic [9:0]  miss_count;
  logic [15:0] set;
  logic [15:0] next_status;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rx_count <= '0;
    end else if (ev.rx_frame_start) begin
      rx_count <= '0;
    end else if (ev.rx_byte && rx_count != EARLY_RX_BYTES) begin
      rx_count <= rx_count + 8'd1;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      coll_count <= '0;
      miss_count <= '0;
    end else begin
      if (tx_collision) coll_count <= coll_count + 10'd1;
      if (ev.rx_lost) miss_count <= miss_count + 10'd1;
    end
  end

  always_comb begin
    set = '0;
    set[POS_SW_INT]      = sw_request;
    set[POS_RX_DMA]      = ev.rx_dma_done;
    set[POS_TX_SPACE]    = ev.tx_space_ready;
    set[POS_TX_UNDERRUN] = ev.tx_underrun;
    set[POS_RX_LOST]     = ev.rx_lost;
    set[POS_EARLY_RX]    = ev.rx_byte && !ev.rx_frame_start
                           && (rx_count == EARLY_RX_BYTES - 8'd1);
    set[POS_COLL_WRAP]   = tx_collision && (coll_count == WRAP_FROM);
    set[POS_MISS_WRAP]   = ev.rx_lost && (miss_count == WRAP_FROM);
    set[POS_DEST_MATCH]  = ev.rx_dest_match;
    // A new event in the clearing cycle survives the read.
    next_status = ((clear ? 16'h0000 : status) | set) & EVT_MASK;
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      status <= '0;
      irq    <= 1'b0;
    end else begin
      status <= next_status;
      // Software interrupts are not masked; every other bit has an enable.
      irq <= |(next_status & (enables | (16'h0001 << POS_SW_INT)));
    end
  end

endmodule : buf_events

`default_nettype wire

// *** hdl/tx_command_buffer_irq_config.sv ***
// Top of the transmit command and buffer interrupt configuration block.
// Assumes an Avalon-MM master on mclk and MAC strobes on the same clock.
`default_nettype none

// ==========================================================================
// Top module
module tx_command_buffer_irq_config
  import tx_command_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic [11:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        eeprom_load,
  input  wire logic [15:0] eeprom_tx_cmd,
  input  wire logic [15:0] eeprom_buf_cfg,
  input  wire logic [10:0] tx_bytes_buffered,
  input  wire logic        tx_collision,
  input  wire logic        tx_done,
  input  wire buf_events_s mac_events,
  output var  tx_ctrl_s    tx_ctrl,
  output logic             irq
);

  logic [15:0] transmit_command_view;
  logic [15:0] buffer_interrupt_config;
  logic [10:0] transmit_length;
  logic [15:0] buffer_event_status;
  logic        accept;
  logic        wr_accept;
  logic        rd_accept;
  logic        cmd_strobe;
  logic        sw_request;
  logic        evt_clear;
  logic        evt_irq;
  logic [15:0] next_cmd;
  logic [15:0] next_length;
  tx_cmd_s     cmd;
  tx_ctrl_s    policy_ctrl;

  // ========================================================================
  // Bus slave
  // A request is answered in the cycle after it is seen; the waitrequest
  // register drops for that one cycle, then rises again.
  assign accept    = (avs_read || avs_write) && avs_waitrequest;
  assign wr_accept = accept && avs_write;
  assign rd_accept = accept && avs_read && !avs_write;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !accept;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      avs_readdata <= '0;
    end else if (rd_accept) begin
      case (avs_address)
        ADDR_TX_CMD_VIEW: avs_readdata <= {16'h0000, transmit_command_view[15:6], ID_TX_CMD};
        ADDR_BUF_CFG:     avs_readdata <= {16'h0000, buffer_interrupt_config[15:6], ID_BUF_CFG};
        ADDR_BUF_EVENT:   avs_readdata <= {16'h0000, buffer_event_status[15:6], ID_BUF_EVT};
        ADDR_TX_LENGTH:   avs_readdata <= {21'h000000, transmit_length};
        default:          avs_readdata <= '0;
      endcase
    end
  end

  // ========================================================================
  // Command and configuration registers
  assign next_cmd   = merge_be(transmit_command_view, avs_writedata[15:0], avs_byteenable[1:0]);
  assign next_length = merge_be({5'h00, transmit_length}, avs_writedata[15:0],
                                avs_byteenable[1:0]);
  assign cmd_strobe = wr_accept && (avs_address == ADDR_TX_CMD_WRITE);
  assign sw_request = wr_accept && (avs_address == ADDR_BUF_CFG) && avs_byteenable[0]
                      && avs_writedata[POS_SW_INT];
  assign evt_clear  = rd_accept && (avs_address == ADDR_BUF_EVENT);

  assign cmd.padding_disable = transmit_command_view[POS_PAD_DIS];
  assign cmd.crc_suppress    = transmit_command_view[POS_CRC_SUPP];
  assign cmd.one_collision   = transmit_command_view[POS_ONE_COLL];
  assign cmd.purge           = transmit_command_view[POS_PURGE];
  assign cmd.start_threshold = transmit_command_view[POS_START_LO+1:POS_START_LO];

  // The policy engine sees the command one cycle after the write, when the
  // view register already holds it.
  logic cmd_pending;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      transmit_command_view <= RESET_TX_CMD;
      cmd_pending           <= 1'b0;
    end else begin
      cmd_pending <= cmd_strobe;
      if (cmd_strobe) begin
        transmit_command_view <= {next_cmd[15:6], ID_TX_CMD};
      end else if (eeprom_load) begin
        transmit_command_view <= {eeprom_tx_cmd[15:6], ID_TX_CMD};
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      buffer_interrupt_config <= RESET_BUF_CFG;
    end else if (wr_accept && avs_address == ADDR_BUF_CFG) begin
      buffer_interrupt_config <= (merge_be(buffer_interrupt_config, avs_writedata[15:0],
                                           avs_byteenable[1:0]) & CFG_WRITABLE) | {10'h000, ID_BUF_CFG};
    end else if (eeprom_load) begin
      buffer_interrupt_config <= (eeprom_buf_cfg & CFG_WRITABLE) | {10'h000, ID_BUF_CFG};
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      transmit_length <= '0;
    end else if (wr_accept && avs_address == ADDR_TX_LENGTH) begin
      transmit_length <= next_length[10:0];
    end
  end

  // ========================================================================
  // Transmit policy and buffer events
  tx_policy u_policy (
    .mclk              (mclk),
    .rstn              (rstn),
    .cmd_strobe        (cmd_pending),
    .cmd               (cmd),
    .tx_length         (transmit_length),
    .tx_bytes_buffered (tx_bytes_buffered),
    .tx_collision      (tx_collision),
    .tx_done           (tx_done),
    .ctrl              (policy_ctrl)
  );

  buf_events u_events (
    .mclk         (mclk),
    .rstn         (rstn),
    .ev           (mac_events),
    .tx_collision (tx_collision),
    .sw_request   (sw_request),
    .clear        (evt_clear),
    .enables      (buffer_interrupt_config),
    .status       (buffer_event_status),
    .irq          (evt_irq)
  );

  assign tx_ctrl = policy_ctrl;
  assign irq     = evt_irq;

endmodule : tx_command_buffer_irq_config

`default_nettype wire

// *** verif/tx_command_buffer_irq_config_monitor.sv ***
// Checker for the transmit command and buffer interrupt block, bound to its top.
// Assumes one clock, mclk, and the asynchronous active-low reset rstn.
`default_nettype none

// ==========================================================================
// Checker
module tx_command_buffer_irq_config_monitor
  import tx_command_pkg::*;
(
  input wire logic        mclk,
  input wire logic        rstn,
  input wire logic [11:0] avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        tx_collision,
  input wire buf_events_s mac_events,
  input wire tx_ctrl_s    tx_ctrl,
  input wire logic        irq
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  AST_ONE_WAIT: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest ##1 avs_waitrequest) else $error("bus answer not one cycle");
  AST_VIEW_ID: assert property (avs_read && avs_waitrequest
    && avs_address == ADDR_TX_CMD_VIEW |=> avs_readdata[5:0] == ID_TX_CMD)
    else $error("view identifier wrong");
  AST_CFG_ID: assert property (avs_read && avs_waitrequest
    && avs_address == ADDR_BUF_CFG |=> avs_readdata[5:0] == ID_BUF_CFG)
    else $error("config identifier wrong");
  AST_UPPER_ZERO: assert property (avs_read && avs_waitrequest
    |=> avs_readdata[31:16] == 16'h0000) else $error("upper read half not zero");
  AST_PURGE: assert property (avs_write && avs_waitrequest && avs_address == ADDR_TX_CMD_WRITE
    && avs_byteenable[1] && avs_writedata[POS_PURGE] |-> ##2 tx_ctrl.purge)
    else $error("purge pulse missing");
  AST_START_PULSE: assert property (tx_ctrl.start |=> !tx_ctrl.start)
    else $error("start wider than one cycle");
  AST_REFUSE_NO_START: assert property (tx_ctrl.refuse |-> !tx_ctrl.start ##1 !tx_ctrl.start)
    else $error("refused frame started");
  AST_EVT_CLEAR: assert property (avs_read && avs_waitrequest && avs_address == ADDR_BUF_EVENT
    && mac_events == '0 && !tx_collision |=> !irq) else $error("irq left after event read");
  AST_RESET: assert property ($rose(rstn) |-> avs_waitrequest && tx_ctrl == '0 && !irq)
    else $error("outputs not at reset state");
endmodule : tx_command_buffer_irq_config_monitor

bind tx_command_buffer_irq_config tx_command_buffer_irq_config_monitor i_mon (
  .mclk(mclk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .tx_collision(tx_collision), .mac_events(mac_events), .tx_ctrl(tx_ctrl), .irq(irq));

`default_nettype wire

// *** verif/mac_model.sv ***
// Behavioural transmit MAC on the far side of the policy outputs.
// Assumes the bench sets fill, frame length and collision count per frame.
`default_nettype none

// ==========================================================================
// MAC model
module mac_model
  import tx_command_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic        fill,
  input  wire logic [10:0] frame_len,
  input  wire logic [4:0]  coll_n,
  input  wire tx_ctrl_s    ctrl,
  output logic [10:0]      bytes,
  output logic             coll,
  output logic             done
);
  timeunit 1ns;
  timeprecision 100ps;
  logic       active;
  logic [4:0] timer;
  logic [4:0] left;

  // Each attempt lasts 21 cycles so that a purge can land in mid-frame.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      bytes  <= 11'h000;
      coll   <= 1'b0;
      done   <= 1'b0;
      active <= 1'b0;
      timer  <= 5'h00;
      left   <= 5'h00;
    end else begin
      coll  <= 1'b0;
      done  <= 1'b0;
      bytes <= !fill ? 11'h000 : (bytes < frame_len ? bytes + 11'h001 : bytes);
      if (ctrl.start) begin
        active <= 1'b1;
        timer  <= 5'h00;
        left   <= coll_n;
      end else if (ctrl.retry) begin
        active <= 1'b1;
        timer  <= 5'h00;
      end else if (ctrl.give_up || ctrl.abort_bad_crc || ctrl.purge) begin
        active <= 1'b0;
      end else if (active) begin
        timer <= timer + 5'h01;
        if (timer == 5'h14) begin
          active <= 1'b0;
          if (left != 5'h00) begin
            coll <= 1'b1;
            left <= left - 5'h01;
          end else begin
            done <= 1'b1;
          end
        end
      end
    end
  end
endmodule : mac_model

`default_nettype wire

// *** verif/tx_command_buffer_irq_config_tb.sv ***
// Self-checking bench: register bus, transmit policy rows, purge and buffer events.
// Assumes the design answers each bus request with one low cycle of waitrequest.
`default_nettype none

// ==========================================================================
// Bench
module tx_command_buffer_irq_config_tb
  import tx_command_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  typedef struct {logic [15:0] cmd; logic [10:0] len; logic [4:0] ncoll; logic [10:0] thr;} row_s;
  row_s        rows [6] = '{'{16'h0000, 11'd40, 5'd0, 11'd5}, '{16'h1200, 11'd50, 5'd2, 11'd5},
                            '{16'h0040, 11'd400, 5'd2, 11'd381}, '{16'h3080, 11'd1100, 5'd0, 11'd1021},
                            '{16'h20c0, 11'd30, 5'd16, 11'd30}, '{16'h0000, 11'd2, 5'd0, 11'd0}};
  logic        mclk = 1'b0;
  logic        rstn = 1'b0;
  logic [11:0] avs_address = 12'h000;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [10:0] tx_bytes_buffered;
  logic        p_coll, tb_coll = 1'b0, tx_done, fill = 1'b0, irq, ee = 1'b0;
  logic [10:0] frame_len = 11'h000;
  logic [4:0]  coll_n = 5'h00;
  buf_events_s ev = '0;
  tx_ctrl_s    tx_ctrl;
  int          fails = 0;
  int          samples_checked = 0;

  always #2.5 mclk = ~mclk;

  tx_command_buffer_irq_config i_dut (.mclk(mclk), .rstn(rstn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'h3), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .eeprom_load(ee), .eeprom_tx_cmd(16'h3355), .eeprom_buf_cfg(16'hffff),
    .tx_bytes_buffered(tx_bytes_buffered), .tx_collision(p_coll | tb_coll), .tx_done(tx_done),
    .mac_events(ev), .tx_ctrl(tx_ctrl), .irq(irq));
  mac_model i_mac (.mclk(mclk), .rstn(rstn), .fill(fill), .frame_len(frame_len),
    .coll_n(coll_n), .ctrl(tx_ctrl), .bytes(tx_bytes_buffered), .coll(p_coll), .done(tx_done));

  task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp

  // The request is held until waitrequest is sampled low; data is taken at that edge.
  task automatic bus(input logic wr, input logic [11:0] a, input logic [15:0] d,
                     output logic [15:0] q);
    @(posedge mclk);
    avs_address   <= a;
    avs_write     <= wr;
    avs_read      <= !wr;
    avs_writedata <= {16'h0000, d};
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata[15:0];
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    logic [15:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rdc(input string nm, input logic [11:0] a, input logic [15:0] e);
    logic [15:0] q;
    bus(1'b0, a, 16'h0000, q);
    cmp(nm, e, q);
  endtask : rdc

  task automatic pulse(input buf_events_s e);
    @(posedge mclk);
    ev <= e;
    @(posedge mclk);
    ev <= '0;
  endtask : pulse

  task automatic test_done;
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : test_done

  initial begin
    #200000;
    fails++;
    test_done;
  end

  initial begin
    row_s        r;
    logic        st, gu, rf, dn, ab, pg, g;
    logic [10:0] bb;
    logic [15:0] nr;
    repeat (12) @(posedge mclk);
    rstn <= 1'b1;
    rdc("view_reset", ADDR_TX_CMD_VIEW, RESET_TX_CMD);
    rdc("cfg_reset", ADDR_BUF_CFG, RESET_BUF_CFG);
    rdc("event_reset", ADDR_BUF_EVENT, 16'h000c);
    wr(ADDR_TX_CMD_VIEW, 16'hffff);
    rdc("view_ro", ADDR_TX_CMD_VIEW, RESET_TX_CMD);
    rdc("unmapped", 12'h000, 16'h0000);
    foreach (rows[i]) begin
      r = rows[i];
      fill      <= 1'b0;
      frame_len <= r.len;
      coll_n    <= r.ncoll;
      wr(ADDR_TX_LENGTH, {5'h00, r.len});
      wr(ADDR_TX_CMD_WRITE, r.cmd);
      fill <= 1'b1;
      {st, gu, rf, dn, nr, bb} = '0;
      for (int n = 0; n < 3000 && !(dn | gu | rf); n++) begin
        @(posedge mclk);
        if (tx_ctrl.start === 1'b1) begin
          st = 1'b1;
          bb = tx_bytes_buffered;
        end
        nr += {15'h0, tx_ctrl.retry === 1'b1};
        gu |= tx_ctrl.give_up === 1'b1;
        rf |= tx_ctrl.refuse === 1'b1;
        dn |= tx_done === 1'b1;
      end
      g = r.cmd[9] ? r.ncoll != 5'd0 : r.ncoll >= 5'd16;
      cmp("refuse", {15'h0, r.len < 11'd3}, {15'h0, rf});
      cmp("start", {15'h0, r.len >= 11'd3}, {15'h0, st});
      if (st) begin
        cmp("thr_hit", 16'h0001, {15'h0, bb >= r.thr && bb <= r.thr + 11'd2});
        cmp("crc", {15'h0, ~r.cmd[12]}, {15'h0, tx_ctrl.append_crc});
        cmp("pad", {15'h0, ~r.cmd[13] & (r.len < 11'd60)}, {15'h0, tx_ctrl.pad_to_min});
        cmp("give_up", {15'h0, g}, {15'h0, gu});
        cmp("retries", g ? (r.cmd[9] ? 16'd0 : 16'd15) : {11'h0, r.ncoll}, nr);
      end
      rdc("view", ADDR_TX_CMD_VIEW, r.cmd | 16'h0009);
    end
    fill <= 1'b0;
    coll_n <= 5'd0;
    frame_len <= 11'd200;
    wr(ADDR_TX_LENGTH, 16'd200);
    wr(ADDR_TX_CMD_WRITE, 16'h0000);
    fill <= 1'b1;
    for (int n = 0; n < 100 && tx_ctrl.start !== 1'b1; n++) @(posedge mclk);
    wr(ADDR_TX_CMD_WRITE, 16'h0100);
    {ab, pg} = '0;
    repeat (8) begin
      @(posedge mclk);
      ab |= tx_ctrl.abort_bad_crc === 1'b1;
      pg |= tx_ctrl.purge === 1'b1;
    end
    cmp("abort_bad_crc", 16'h0001, {15'h0, ab});
    cmp("purge", 16'h0001, {15'h0, pg});
    wr(ADDR_BUF_CFG, 16'hbf80);
    rdc("cfg_rw", ADDR_BUF_CFG, 16'hbf8b);
    rdc("event_idle", ADDR_BUF_EVENT, 16'h000c);
    wr(ADDR_BUF_CFG, 16'h0440);
    rdc("event_sw", ADDR_BUF_EVENT, 16'h004c);
    pulse(7'h08);
    @(posedge mclk);
    cmp("irq_lost", 16'h0001, {15'h0, irq});
    rdc("event_lost", ADDR_BUF_EVENT, 16'h040c);
    repeat (2) @(posedge mclk);
    cmp("irq_clear", 16'h0000, {15'h0, irq});
    // Destination match is left masked here, so only the early-receive bit may raise irq.
    wr(ADDR_BUF_CFG, 16'h0800);
    pulse(7'h01);
    pulse(7'h04);
    repeat (127) pulse(7'h02);
    @(posedge mclk);
    cmp("irq_127", 16'h0000, {15'h0, irq});
    pulse(7'h02);
    @(posedge mclk);
    cmp("irq_128", 16'h0001, {15'h0, irq});
    rdc("event_early", ADDR_BUF_EVENT, 16'h880c);
    // The rows above already produced 19 collisions, so 493 more reach 200h.
    repeat (493) begin
      @(posedge mclk);
      tb_coll <= 1'b1;
      @(posedge mclk);
      tb_coll <= 1'b0;
    end
    rdc("event_wrap", ADDR_BUF_EVENT, 16'h100c);
    // Preload: id bits stay fixed, only writable configuration bits follow the source.
    ee <= 1'b1;
    @(posedge mclk);
    ee <= 1'b0;
    rdc("view_eeprom", ADDR_TX_CMD_VIEW, 16'h3349);
    rdc("cfg_eeprom", ADDR_BUF_CFG, 16'hbfcb);
    test_done;
  end
endmodule : tx_command_buffer_irq_config_tb

`default_nettype wire
